// [cdfe_front_end.sv]
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module cdfe_front_end
  import cdfe_pkg::*;
(
  // APB clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // Mode and shared control pins.
  input wire logic control_mode_pin,
  input wire logic serial_clk,
  input wire logic frame_latch,
  input wire logic serial_in,
  input wire logic addr_strap_2,
  input wire logic addr_strap_1,
  input wire logic addr_strap_0,
  input wire logic clear_pin,
  input wire logic clear_level_select,
  input wire logic reset_pin_n,
  // Analog fault detectors.
  input wire logic overtemp_det,
  input wire logic open_circuit_det,
  // Serial readback output.
  output logic readback_out,
  // Open-drain fault pins.
  output logic fault_alert_n_o,
  output logic fault_alert_n_oe,
  output logic open_loop_alert_n_o,
  output logic open_loop_alert_n_oe,
  // Controls to the analog output stage.
  output logic [3:0] range_sel,
  output logic drive_enable,
  output logic sense_internal,
  output logic clear_force,
  output logic clear_midscale
);

  logic [PIN_W-1:0] pins_s;
  logic sclk_prev_q;
  logic latch_prev_q;
  logic ot_prev_q;
  logic oc_prev_q;
  logic sw_mode;
  logic dev_rst;
  logic sclk_fall;
  logic sclk_rise;
  logic latch_rise;
  logic latch_fall;
  logic [2:0] strap_addr;
  cdfe_link_t link_q;
  logic [23:0] shift_q;
  logic [4:0] bit_cnt_q;
  logic [7:0] crc;
  logic crc_step;
  logic [15:0] ctrl_q;
  logic [15:0] rb_q;
  logic rb_pend_q;
  logic rb_active_q;
  logic chk_err_q;
  logic chk_on_q;
  logic [15:0] frame_word;
  logic len_ok;
  logic addr_ok;
  logic crc_ok;
  logic frame_good;
  logic frame_bad_crc;
  logic [ST_W-1:0] events;
  logic [ST_W-1:0] status_q;
  logic [ST_W-1:0] status_d;
  logic [ST_W-1:0] enable_q;
  logic [ST_W-1:0] clear_mask;
  logic wr_en;
  logic [31:0] rd_data;
  logic rd_hit;

  // Matches an aligned word offset.
  function automatic logic reg_hit(input logic [7:0] a,
                                   input logic [7:0] off);
    reg_hit = (a[7:2] == off[7:2]);
  endfunction

  // Every pin from outside passes two flip-flops first.
  cdfe_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pins({open_circuit_det, overtemp_det, reset_pin_n, clear_level_select,
           clear_pin, addr_strap_0, addr_strap_1, addr_strap_2, serial_in,
           frame_latch, serial_clk, control_mode_pin}),
    .pins_s(pins_s)
  );

  // Mode select and the software-mode reset.
  assign sw_mode = ~pins_s[P_MODE];
  assign dev_rst = sw_mode & ~pins_s[P_RSTN];
  assign strap_addr = {pins_s[P_STRAP2], pins_s[P_STRAP1], pins_s[P_STRAP0]};

  // Edge finders on the synchronised levels.
  assign sclk_fall = sclk_prev_q & ~pins_s[P_SCLK];
  assign sclk_rise = ~sclk_prev_q & pins_s[P_SCLK];
  assign latch_rise = ~latch_prev_q & pins_s[P_LATCH];
  assign latch_fall = latch_prev_q & ~pins_s[P_LATCH];

  // Previous levels for edge and fault onset detection.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_prev_q <= PIN_RESET[P_SCLK];
      latch_prev_q <= PIN_RESET[P_LATCH];
      ot_prev_q <= PIN_RESET[P_OT];
      oc_prev_q <= PIN_RESET[P_OC];
    end else begin
      sclk_prev_q <= pins_s[P_SCLK];
      latch_prev_q <= pins_s[P_LATCH];
      ot_prev_q <= pins_s[P_OT];
      oc_prev_q <= pins_s[P_OC];
    end
  end

  // Frame state: a falling latch opens it, a rising latch closes it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_q <= LINK_IDLE;
    end else if (dev_rst || !sw_mode) begin
      link_q <= LINK_IDLE;
    end else begin
      case (link_q)
        LINK_IDLE: begin
          if (latch_fall) begin
            link_q <= LINK_SHIFT;
          end
        end
        LINK_SHIFT: begin
          if (latch_rise) begin
            link_q <= LINK_IDLE;
          end
        end
        default: begin
          link_q <= LINK_IDLE;
        end
      endcase
    end
  end

  // Input shift register and bit counter, sampled on falling clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_q <= 24'h000000;
      bit_cnt_q <= 5'd0;
    end else if (dev_rst) begin
      shift_q <= 24'h000000;
      bit_cnt_q <= 5'd0;
    end else if (link_q == LINK_IDLE && latch_fall) begin
      bit_cnt_q <= 5'd0;
    end else if (link_q == LINK_SHIFT && sclk_fall && sw_mode) begin
      shift_q <= {shift_q[22:0], pins_s[P_SER_IN]};
      if (bit_cnt_q != BIT_CNT_MAX) begin
        bit_cnt_q <= bit_cnt_q + 5'd1;
      end
    end
  end

  // Check code runs over the first sixteen bits only.
  assign crc_step = (link_q == LINK_SHIFT) && sclk_fall && sw_mode &&
                    (bit_cnt_q < FRAME_BITS);

  cdfe_crc8 u_crc (
    .pclk(pclk),
    .presetn(presetn),
    .start(link_q == LINK_IDLE),
    .step(crc_step),
    .bit_in(pins_s[P_SER_IN]),
    .crc(crc)
  );

  // Frame judgement at the rising latch edge.
  always_comb begin
    frame_word = chk_on_q ? shift_q[23:8] : shift_q[15:0];
    len_ok = chk_on_q ? (bit_cnt_q == CHK_FRAME_BITS)
                      : (bit_cnt_q == FRAME_BITS);
    addr_ok = (frame_word[ADDR_MSB:ADDR_LSB] == strap_addr);
    crc_ok = !chk_on_q || (crc == shift_q[7:0]);
    frame_good = (link_q == LINK_SHIFT) && latch_rise && len_ok &&
                 addr_ok && crc_ok;
    frame_bad_crc = (link_q == LINK_SHIFT) && latch_rise && len_ok &&
                    addr_ok && !crc_ok;
  end

  // Parallel load of the control word.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (dev_rst) begin
      ctrl_q <= CTRL_RESET;
    end else if (frame_good) begin
      ctrl_q <= frame_word;
    end
  end

  // Interface check fault stays until the next good frame.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chk_err_q <= 1'b0;
    end else if (dev_rst || frame_good) begin
      chk_err_q <= 1'b0;
    end else if (frame_bad_crc) begin
      chk_err_q <= 1'b1;
    end
  end

  // Readback: a read request arms the next frame to shift out.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rb_q <= 16'h0000;
      rb_pend_q <= 1'b0;
      rb_active_q <= 1'b0;
    end else if (dev_rst || !sw_mode) begin
      rb_q <= 16'h0000;
      rb_pend_q <= 1'b0;
      rb_active_q <= 1'b0;
    end else if (latch_rise && link_q == LINK_SHIFT) begin
      rb_active_q <= 1'b0;
      rb_pend_q <= frame_good && frame_word[READ_BIT];
      if (frame_good) begin
        rb_q <= frame_word;
      end
    end else if (link_q == LINK_IDLE && latch_fall && rb_pend_q) begin
      rb_active_q <= 1'b1;
      rb_pend_q <= 1'b0;
      rb_q <= {rb_q[14:0], 1'b0};
    end else if (link_q == LINK_SHIFT && rb_active_q && sclk_rise) begin
      rb_q <= {rb_q[14:0], 1'b0};
    end
  end

  // Readback pin: first bit at frame open, then one per rising clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      readback_out <= 1'b0;
    end else if (dev_rst || !sw_mode) begin
      readback_out <= 1'b0;
    end else if (link_q == LINK_IDLE && latch_fall && rb_pend_q) begin
      readback_out <= rb_q[15];
    end else if (link_q == LINK_SHIFT && rb_active_q && sclk_rise) begin
      readback_out <= rb_q[15];
    end else if (!rb_active_q) begin
      readback_out <= 1'b0;
    end
  end

  // Output stage controls follow the mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      range_sel <= 4'h0;
      drive_enable <= 1'b0;
      sense_internal <= 1'b0;
    end else if (sw_mode) begin
      range_sel <= ctrl_q[RANGE_MSB:0];
      drive_enable <= ctrl_q[OUT_ON_BIT];
      sense_internal <= ctrl_q[SENSE_BIT];
    end else begin
      range_sel <= {pins_s[P_STRAP0], pins_s[P_STRAP1], pins_s[P_STRAP2],
                    pins_s[P_SER_IN]};
      drive_enable <= pins_s[P_SCLK];
      sense_internal <= pins_s[P_LATCH];
    end
  end

  // Clear request and level: pin, OR internal bit in software mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clear_force <= 1'b0;
      clear_midscale <= 1'b0;
    end else begin
      clear_force <= pins_s[P_CLEAR] |
                     (sw_mode & ctrl_q[CLEAR_BIT]);
      clear_midscale <= pins_s[P_LVL_SEL] |
                        (sw_mode & ctrl_q[LVL_SEL_BIT]);
    end
  end

  // Open-drain fault pins pull low only while their fault is present.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_alert_n_o <= 1'b0;
      fault_alert_n_oe <= 1'b0;
      open_loop_alert_n_o <= 1'b0;
      open_loop_alert_n_oe <= 1'b0;
    end else begin
      fault_alert_n_o <= 1'b0;
      open_loop_alert_n_o <= 1'b0;
      if (sw_mode) begin
        fault_alert_n_oe <= pins_s[P_OT] | pins_s[P_OC] |
                            chk_err_q;
      end else begin
        fault_alert_n_oe <= pins_s[P_OT];
      end
      open_loop_alert_n_oe <= ~sw_mode & pins_s[P_OC];
    end
  end

  // Events and sticky status; a new event beats a same-cycle clear.
  assign events[ST_FRAME] = frame_good;
  assign events[ST_CHK_ERR] = frame_bad_crc;
  assign events[ST_OVERTEMP] = pins_s[P_OT] & ~ot_prev_q;
  assign events[ST_OPEN] = pins_s[P_OC] & ~oc_prev_q;
  assign wr_en = psel & penable & pready & pwrite;
  assign clear_mask = (wr_en && reg_hit(paddr, OFF_IRQ_CLEAR)) ?
                      pwdata[ST_W-1:0] : {ST_W{1'b0}};
  assign status_d = (status_q & ~clear_mask) | events;

  // Status, enable and configuration registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= STATUS_RESET;
      enable_q <= ENABLE_RESET;
      chk_on_q <= CONFIG_RESET;
      irq <= 1'b0;
    end else begin
      status_q <= status_d;
      irq <= |(status_d & enable_q);
      if (wr_en && reg_hit(paddr, OFF_IRQ_ENABLE)) begin
        enable_q <= pwdata[ST_W-1:0];
      end
      if (wr_en && reg_hit(paddr, OFF_CONFIG)) begin
        chk_on_q <= pwdata[CFG_CHK_BIT];
      end
    end
  end

  // Read multiplexer; the clear register reads as zero.
  always_comb begin
    rd_data = 32'h00000000;
    rd_hit = 1'b1;
    if (reg_hit(paddr, OFF_STATUS)) begin
      rd_data[ST_W-1:0] = status_q;
    end else if (reg_hit(paddr, OFF_IRQ_CLEAR)) begin
      rd_data = 32'h00000000;
    end else if (reg_hit(paddr, OFF_IRQ_ENABLE)) begin
      rd_data[ST_W-1:0] = enable_q;
    end else if (reg_hit(paddr, OFF_CONFIG)) begin
      rd_data[CFG_CHK_BIT] = chk_on_q;
    end else if (reg_hit(paddr, OFF_STATE)) begin
      rd_data = {9'h000, chk_err_q, pins_s[P_OC], pins_s[P_OT],
                 sw_mode, strap_addr, ctrl_q};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // APB answer: no wait state, ready in the first access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      pslverr <= ~rd_hit;
      prdata <= (!pwrite && rd_hit) ? rd_data : 32'h00000000;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
  end

endmodule // cdfe_front_end
`default_nettype wire

// [cdfe_pkg.sv]
package cdfe_pkg;

  // Serial frame lengths and check code.
  localparam logic [4:0] FRAME_BITS = 5'd16;
  localparam logic [4:0] CHK_FRAME_BITS = 5'd24;
  localparam logic [4:0] BIT_CNT_MAX = 5'h1f;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;

  // Control word field positions.
  localparam int ADDR_MSB = 15;
  localparam int ADDR_LSB = 13;
  localparam int READ_BIT = 12;
  localparam int CLEAR_BIT = 11;
  localparam int LVL_SEL_BIT = 10;
  localparam int OUT_ON_BIT = 9;
  localparam int SENSE_BIT = 8;
  localparam int RANGE_MSB = 3;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // Register map, byte addresses.
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h04;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h08;
  localparam logic [7:0] OFF_CONFIG = 8'h0c;
  localparam logic [7:0] OFF_STATE = 8'h10;

  // Status bit positions and reset values.
  localparam int ST_FRAME = 0;
  localparam int ST_CHK_ERR = 1;
  localparam int ST_OVERTEMP = 2;
  localparam int ST_OPEN = 3;
  localparam int ST_W = 4;
  localparam logic [3:0] STATUS_RESET = 4'h0;
  localparam logic [3:0] ENABLE_RESET = 4'h0;
  localparam int CFG_CHK_BIT = 0;
  localparam logic CONFIG_RESET = 1'b0;

  // Synchronised pin bank positions.
  localparam int PIN_W = 12;
  localparam int P_MODE = 0;
  localparam int P_SCLK = 1;
  localparam int P_LATCH = 2;
  localparam int P_SER_IN = 3;
  localparam int P_STRAP2 = 4;
  localparam int P_STRAP1 = 5;
  localparam int P_STRAP0 = 6;
  localparam int P_CLEAR = 7;
  localparam int P_LVL_SEL = 8;
  localparam int P_RSTN = 9;
  localparam int P_OT = 10;
  localparam int P_OC = 11;
  // Reset pin idles high, serial clock and latch idle high.
  localparam logic [11:0] PIN_RESET = 12'h206;

  // Serial link states.
  typedef enum logic [0:0] {LINK_IDLE, LINK_SHIFT} cdfe_link_t;

endpackage

// [cdfe_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module cdfe_sync
  import cdfe_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Raw pins and their synchronised levels.
  input wire logic [PIN_W-1:0] pins,
  output logic [PIN_W-1:0] pins_s
);

  logic [PIN_W-1:0] meta_q;

  // Two flip-flops per pin; only the second stage is read outside.
  genvar i;
  generate
    for (i = 0; i < PIN_W; i++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_q[i] <= PIN_RESET[i];
          pins_s[i] <= PIN_RESET[i];
        end else begin
          meta_q[i] <= pins[i];
          pins_s[i] <= meta_q[i];
        end
      end
    end
  endgenerate

endmodule // cdfe_sync
`default_nettype wire

// [cdfe_crc8.sv]
`timescale 1ns/1ps
`default_nettype none
module cdfe_crc8
  import cdfe_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Restart and one-bit step.
  input wire logic start,
  input wire logic step,
  input wire logic bit_in,
  output logic [7:0] crc
);

  logic fb;

  // Feedback of the serial shift.
  assign fb = crc[7] ^ bit_in;

  // Serial check code, MSB first; restart has priority.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc <= CRC_INIT;
    end else if (start) begin
      crc <= CRC_INIT;
    end else if (step) begin
      crc <= {crc[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
    end
  end

endmodule // cdfe_crc8
`default_nettype wire

// [cdfe_front_end_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module cdfe_front_end_asserts (
  // Clock, reset and bus handshake.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Pins from outside.
  input wire logic control_mode_pin,
  input wire logic serial_clk,
  input wire logic frame_latch,
  input wire logic serial_in,
  input wire logic addr_strap_2,
  input wire logic addr_strap_1,
  input wire logic addr_strap_0,
  input wire logic clear_pin,
  input wire logic overtemp_det,
  input wire logic open_circuit_det,
  // Outputs under watch.
  input wire logic fault_alert_n_oe,
  input wire logic open_loop_alert_n_oe,
  input wire logic [3:0] range_sel,
  input wire logic drive_enable,
  input wire logic sense_internal,
  input wire logic clear_force
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // The bus answers in the access phase right after setup.
  chk_ready_next: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  chk_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  chk_err_qual: assert property (pslverr |-> pready)
    else $error("pslverr without pready");

  // Hardware mode: steady pins reach the stage controls.
  chk_hw_range: assert property (
    (control_mode_pin && $stable({control_mode_pin, serial_in,
      addr_strap_2, addr_strap_1, addr_strap_0}))[*8]
    |-> range_sel == {addr_strap_0, addr_strap_1, addr_strap_2, serial_in})
    else $error("range code mismatch");
  chk_hw_enable: assert property (
    (control_mode_pin && $stable({control_mode_pin, serial_clk}))[*8]
    |-> drive_enable == serial_clk) else $error("output enable mismatch");
  chk_hw_sense: assert property (
    (control_mode_pin && $stable({control_mode_pin, frame_latch}))[*8]
    |-> sense_internal == frame_latch) else $error("sense select mismatch");

  // Fault pins follow the detectors within a few cycles.
  chk_ot_pull: assert property (
    $rose(overtemp_det) |-> ##[2:6] fault_alert_n_oe)
    else $error("overtemperature not flagged");
  chk_oc_pull: assert property (
    $rose(open_circuit_det) && control_mode_pin
    |-> ##[2:6] open_loop_alert_n_oe) else $error("open circuit not flagged");
  chk_ot_release: assert property (
    $fell(overtemp_det) && control_mode_pin |-> ##[2:6] !fault_alert_n_oe)
    else $error("fault pin not released");
  chk_sw_open_idle: assert property (
    (!control_mode_pin)[*8] |-> !open_loop_alert_n_oe)
    else $error("open-circuit pin driven in software mode");
  chk_clear_force: assert property (
    $rose(clear_pin) |-> ##[2:6] clear_force) else $error("clear not forced");

  // Main scenarios reached.
  cov_sw_fault: cover property (!control_mode_pin && fault_alert_n_oe);
  cov_refused: cover property (pslverr);
  cov_hw_range: cover property (control_mode_pin && range_sel == 4'hf);
  cov_clear: cover property (clear_force);
endmodule // cdfe_front_end_asserts

bind cdfe_front_end cdfe_front_end_asserts u_chk (
  .pclk, .presetn, .psel, .penable, .pready, .pslverr, .control_mode_pin,
  .serial_clk, .frame_latch, .serial_in, .addr_strap_2, .addr_strap_1,
  .addr_strap_0, .clear_pin, .overtemp_det, .open_circuit_det,
  .fault_alert_n_oe, .open_loop_alert_n_oe, .range_sel, .drive_enable,
  .sense_internal, .clear_force
);
`default_nettype wire

// [cdfe_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cdfe_host_model (
  // Serial lines driven by the host.
  output var logic serial_clk,
  output var logic frame_latch,
  output var logic serial_in,
  // Readback from the device.
  input wire logic readback_out
);
  // Clock and latch idle high between frames.
  initial begin
    serial_clk = 1'b1;
    frame_latch = 1'b1;
    serial_in = 1'b0;
  end

  // Sends n bits MSB first at an 80 ns period and collects readback.
  task automatic frame(input logic [23:0] w, input int n,
                       output logic [23:0] rb);
    rb = 24'h0;
    #3 frame_latch = 1'b0;
    #40;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = w[i];
      #40 rb = {rb[22:0], readback_out};
      serial_clk = 1'b0;
      #40 serial_clk = 1'b1;
    end
    #20 frame_latch = 1'b1;
    serial_in = ~serial_in;
    #100;
  endtask

  // In hardware mode the same lines carry static levels.
  task automatic set_pins(input logic c, input logic l, input logic d);
    serial_clk <= c;
    frame_latch <= l;
    serial_in <= d;
  endtask
endmodule // cdfe_host_model
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cdfe_pkg::*;
  // Clock, reset and bus master.
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, irq, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  // Board pins and host lines.
  logic control_mode_pin = 1'b0, addr_strap_2 = 1'b1, addr_strap_1 = 1'b0;
  logic addr_strap_0 = 1'b1, clear_pin = 1'b0, clear_level_select = 1'b0;
  logic reset_pin_n = 1'b1, overtemp_det = 1'b0, open_circuit_det = 1'b0;
  logic serial_clk, frame_latch, serial_in, readback_out;
  logic fault_alert_n_o, fault_alert_n_oe;
  logic open_loop_alert_n_o, open_loop_alert_n_oe;
  logic [3:0] range_sel;
  logic drive_enable, sense_internal, clear_force, clear_midscale;
  logic [23:0] rb;
  int err_count = 0, tests_run = 0;
  // Snapshot: pin levels, irq, open oe, fault oe, mid, clr, drv, sense, range.
  // The driven levels of both open-drain pins must always stay low.
  wire [31:0] outs = {19'h0, fault_alert_n_o, open_loop_alert_n_o, irq,
    open_loop_alert_n_oe, fault_alert_n_oe,
    clear_midscale, clear_force, drive_enable, sense_internal, range_sel};

  // Bus clock.
  always #5 pclk = ~pclk;

  cdfe_front_end uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irq, .control_mode_pin,
    .serial_clk, .frame_latch, .serial_in, .addr_strap_2, .addr_strap_1,
    .addr_strap_0, .clear_pin, .clear_level_select, .reset_pin_n,
    .overtemp_det, .open_circuit_det, .readback_out, .fault_alert_n_o,
    .fault_alert_n_oe, .open_loop_alert_n_o, .open_loop_alert_n_oe,
    .range_sel, .drive_enable, .sense_internal, .clear_force,
    .clear_midscale);
  cdfe_host_model host (.serial_clk, .frame_latch, .serial_in,
    .readback_out);

  // Prints the counts and the verdict, then stops.
  task test_done;
    $display("Checks %0d, errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Compares one value.
  task check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus transfer; waits for pready under a bound.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      err_count++;
      $display("ERROR at %0t: no bus answer", $time);
      test_done;
    end else begin
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // Read and compare.
  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask

  // Lets pin changes pass the synchronisers.
  task wt;
    repeat (10) @(posedge pclk);
  endtask

  // One serial frame, then settle.
  task frm(input logic [23:0] w, input int n);
    host.frame(w, n, rb);
    wt;
  endtask

  // Check code over the 16 data bits, MSB first.
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction

  // Main sequence.
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdc(OFF_STATUS, 32'h0);
    rdc(OFF_CONFIG, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    check({31'h0, er}, 32'h1);
    apb(1'b1, OFF_IRQ_ENABLE, 32'hf);
    rdc(OFF_IRQ_ENABLE, 32'hf);
    rdc(OFF_STATE, 32'h000d0000);
    frm(24'h00a305, 16);
    check(outs, 32'h435);
    rdc(OFF_STATUS, 32'h1);
    frm(24'h002000, 16);
    check(outs, 32'h435);
    frm(24'h005000, 15);
    check(outs, 32'h435);
    frm(24'h00af05, 16);
    check(outs, 32'h4f5);
    frm(24'h00b305, 16);
    frm(24'h000000, 16);
    check({8'h0, rb}, 32'h0000b305);
    frm(24'h00a305, 16);
    clear_pin <= 1'b1;
    clear_level_select <= 1'b1;
    wt;
    check(outs, 32'h4f5);
    clear_pin <= 1'b0;
    clear_level_select <= 1'b0;
    apb(1'b1, OFF_IRQ_CLEAR, 32'hf);
    wt;
    check(outs, 32'h035);
    rdc(OFF_STATUS, 32'h0);
    apb(1'b1, OFF_CONFIG, 32'h1);
    frm({16'ha30a, crc8(16'ha30a)}, 24);
    check(outs, 32'h43a);
    frm({16'ha305, ~crc8(16'ha305)}, 24);
    check(outs, 32'h53a);
    rdc(OFF_STATUS, 32'h3);
    frm({16'ha305, crc8(16'ha305)}, 24);
    check(outs, 32'h435);
    apb(1'b1, OFF_CONFIG, 32'h0);
    apb(1'b1, OFF_IRQ_CLEAR, 32'hf);
    apb(1'b1, OFF_IRQ_ENABLE, 32'h4);
    overtemp_det <= 1'b1;
    wt;
    check(outs, 32'h535);
    overtemp_det <= 1'b0;
    open_circuit_det <= 1'b1;
    wt;
    check(outs, 32'h535);
    rdc(OFF_STATUS, 32'hc);
    apb(1'b1, OFF_IRQ_ENABLE, 32'h0);
    wt;
    check(outs, 32'h135);
    open_circuit_det <= 1'b0;
    wt;
    check(outs, 32'h035);
    reset_pin_n <= 1'b0;
    wt;
    reset_pin_n <= 1'b1;
    wt;
    check(outs, 32'h0);
    rdc(OFF_STATE, 32'h000d0000);
    control_mode_pin <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      {addr_strap_0, addr_strap_1, addr_strap_2} <= i[3:1];
      host.set_pins(i[2], i[3], i[0]);
      wt;
      check(outs, {26'h0, i[2], i[3], i[3:0]});
    end
    reset_pin_n <= 1'b0;
    wt;
    check(outs, 32'h03f);
    reset_pin_n <= 1'b1;
    overtemp_det <= 1'b1;
    wt;
    check(outs, 32'h13f);
    overtemp_det <= 1'b0;
    open_circuit_det <= 1'b1;
    wt;
    check(outs, 32'h23f);
    open_circuit_det <= 1'b0;
    wt;
    check(outs, 32'h03f);
    test_done;
  end

  // Cuts a hang short.
  initial begin
    #200000;
    err_count++;
    $display("ERROR at %0t: run timed out", $time);
    test_done;
  end
endmodule // testbench
`default_nettype wire
